// file: rdsw_rx_split_wb.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rdsw_rx_split_wb
	import rdsw_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic desc_valid,
	input wire logic [63:0] desc_qword,
	output logic desc_ready,
	input wire logic info_valid,
	input wire rdsw_info_t info,
	output logic info_ready,
	input wire logic beat_valid,
	input wire rdsw_beat_t beat,
	output logic beat_ready,
	output logic hw_valid,
	output logic [63:0] hw_addr,
	output logic [63:0] hw_data,
	output logic [3:0] hw_bytes,
	output logic wb_valid,
	output logic [1:0] wb_index,
	output logic [63:0] wb_qword,
	output logic [7:0] checksum_start_offset
);
	function automatic logic [15:0] bsize(input logic [31:0] sz,
		input logic [1:0] idx);
		logic [BSIZE_W-1:0] f;
		f = sz[idx*BSIZE_STRIDE +: BSIZE_W];
		return 16'({f, SIZE_UNIT_SHIFT'(0)});
	endfunction

	logic [1:0] descriptor_type_ff;
	logic extended_status_enable_ff;
	logic ip_payload_checksum_enable_ff;
	logic hash_vs_checksum_select_ff;
	logic transport_offload_setting_ff;
	logic [7:0] cstart_ff;
	logic [31:0] split_buffer_size_ff;
	logic [31:0] rdata_ff;
	rdsw_state_t st_ff, nxt_st;
	logic [1:0] ld_cnt_ff;
	logic [1:0] cur_ff, nxt_cur;
	logic [15:0] off_ff, nxt_off;
	logic cont_ff, nxt_cont;
	logic split_ff;
	rdsw_info_t info_ff;
	logic [3:0][15:0] len_ff;
	logic [1:0] wb_cnt_ff;
	logic desc_ready_ff, info_ready_ff, beat_ready_ff;
	logic hw_valid_ff;
	logic [63:0] hw_addr_ff, hw_data_ff;
	logic [3:0] hw_bytes_ff;
	logic wb_valid_ff;
	logic [1:0] wb_index_ff;
	logic [63:0] wb_qword_ff;
	logic [63:0] buf_addr;

	wire wr_ctl = reg_wr && reg_addr == REG_RX_CONTROL;
	wire wr_flt = reg_wr && reg_addr == REG_RX_FILTER_CONTROL;
	wire wr_csm = reg_wr && reg_addr == REG_RX_CHECKSUM_CONTROL;
	wire wr_psz = reg_wr && reg_addr == REG_SPLIT_RX_CONTROL;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			descriptor_type_ff <= DTYPE_RST;
			extended_status_enable_ff <= 1'b0;
			ip_payload_checksum_enable_ff <= 1'b0;
			hash_vs_checksum_select_ff <= 1'b0;
			transport_offload_setting_ff <= 1'b0;
			cstart_ff <= CSTART_RST;
			split_buffer_size_ff <= BSIZE_RST;
		end
		else
		begin
			if (wr_ctl)
				descriptor_type_ff <= reg_wdata[TYPE_LSB +: 2];
			if (wr_flt)
				extended_status_enable_ff <= reg_wdata[EXT_EN_BIT];
			if (wr_csm)
			begin
				ip_payload_checksum_enable_ff <= reg_wdata[IPP_EN_BIT];
				hash_vs_checksum_select_ff <= reg_wdata[SELECT_BIT];
				transport_offload_setting_ff <= reg_wdata[TRANSPORT_OFFLOAD_SETTING_BIT];
				cstart_ff <= reg_wdata[CSTART_LSB +: 8];
			end
			if (wr_psz)
				split_buffer_size_ff <= reg_wdata;
		end
	end

	wire [31:0] rd_mux =
		(reg_addr == REG_RX_CONTROL) ? {30'd0, descriptor_type_ff} :
		(reg_addr == REG_RX_FILTER_CONTROL) ?
			{31'd0, extended_status_enable_ff} :
		(reg_addr == REG_RX_CHECKSUM_CONTROL) ?
			{16'd0, cstart_ff, 5'd0, transport_offload_setting_ff,
			hash_vs_checksum_select_ff, ip_payload_checksum_enable_ff} :
		(reg_addr == REG_SPLIT_RX_CONTROL) ? split_buffer_size_ff :
		(reg_addr == REG_SPLIT_STATUS) ?
			{25'd0, split_ff, cont_ff, cur_ff, ld_cnt_ff == 2'd0, st_ff} :
		32'd0;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			rdata_ff <= '0;
		else
			rdata_ff <= reg_rd ? rd_mux : '0;
	end

	wire split_mode = extended_status_enable_ff &&
		descriptor_type_ff == DTYPE_SPLIT; // RULE11
	wire desc_acc = desc_valid && desc_ready_ff;
	wire info_acc = info_valid && info_ready_ff;
	wire acc = beat_valid && beat_ready_ff;
	wire [15:0] fill = off_ff + 16'(beat.nbytes);
	wire [15:0] cur_sz = bsize(split_buffer_size_ff, cur_ff);
	// Header bytes stay in buffer 0; data moves on once they are placed.
	wire hdr_done = split_ff && cur_ff == 2'd0 &&
		fill >= 16'(info_ff.hdr_len); // RULE15
	wire adv = hdr_done || fill >= cur_sz;
	wire [2:0] nb = {1'b0, cur_ff} + 3'd1;
	wire nb_ok = split_mode && nb < 3'(DESC_WORDS) &&
		bsize(split_buffer_size_ff, nb[1:0]) != 16'd0; // RULE16
	wire do_split = split_mode && info.hdr_len != 10'd0 &&
		16'(info.hdr_len) <= bsize(split_buffer_size_ff, 2'd0); // RULE15
	wire cont_start = split_mode &&
		bsize(split_buffer_size_ff, 2'd1) != 16'd0;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_cur = cur_ff;
		nxt_off = off_ff;
		nxt_cont = cont_ff;
		unique case (st_ff)
			ST_LOAD:
				if (desc_acc && ld_cnt_ff == LAST_WORD)
				begin
					nxt_st = ST_WAIT;
					nxt_cur = 2'd0;
					nxt_off = 16'd0;
				end
			ST_WAIT:
				if (cont_ff)
				begin
					nxt_st = ST_RECV;
					nxt_cur = cont_start ? 2'd1 : 2'd0; // RULE17
				end
				else if (info_acc)
					nxt_st = ST_RECV;
			ST_RECV:
				if (acc)
				begin
					if (beat.last)
					begin
						nxt_st = ST_WB;
						nxt_cont = 1'b0;
					end
					else if (adv && nb_ok)
					begin
						nxt_cur = nb[1:0];
						nxt_off = 16'd0;
					end
					else if (adv)
					begin
						nxt_st = ST_WB;
						nxt_cont = 1'b1;
					end
					else
						nxt_off = fill;
				end
			ST_WB:
				if (wb_cnt_ff == LAST_WORD)
					nxt_st = ST_LOAD;
		endcase
	end

	// Read address follows the next buffer so data line up with cur_ff.
	rdsw_addr_mem #(
		.WIDTH(64),
		.DEPTH(DESC_WORDS),
		.AW(2)
	) u_addr_mem (
		.clock(clock),
		.wr_en(desc_acc), // RULE13
		.wr_addr(ld_cnt_ff),
		.wr_data(desc_qword),
		.rd_addr(nxt_cur),
		.rd_data(buf_addr)
	);

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			st_ff <= ST_LOAD;
			ld_cnt_ff <= 2'd0;
			cur_ff <= 2'd0;
			off_ff <= 16'd0;
			cont_ff <= 1'b0;
			split_ff <= 1'b0;
			info_ff <= '0;
			wb_cnt_ff <= 2'd0;
		end
		else
		begin
			st_ff <= nxt_st;
			cur_ff <= nxt_cur;
			off_ff <= nxt_off;
			cont_ff <= nxt_cont;
			if (desc_acc)
				ld_cnt_ff <= ld_cnt_ff + 2'd1;
			if (info_acc)
			begin
				info_ff <= info;
				split_ff <= do_split; // RULE15
			end
			else if (st_ff == ST_WAIT && cont_ff)
				split_ff <= 1'b0;
			wb_cnt_ff <= (st_ff == ST_WB) ? wb_cnt_ff + 2'd1 : 2'd0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst || st_ff == ST_LOAD)
			len_ff <= '0; // RULE19
		else if (acc)
			len_ff[cur_ff] <= len_ff[cur_ff] + 16'(beat.nbytes); // RULE20
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			desc_ready_ff <= 1'b0;
			info_ready_ff <= 1'b0;
			beat_ready_ff <= 1'b0;
			hw_valid_ff <= 1'b0;
			hw_addr_ff <= '0;
			hw_data_ff <= '0;
			hw_bytes_ff <= '0;
		end
		else
		begin
			desc_ready_ff <= nxt_st == ST_LOAD;
			info_ready_ff <= nxt_st == ST_WAIT && !nxt_cont;
			beat_ready_ff <= nxt_st == ST_RECV;
			hw_valid_ff <= acc;
			if (acc)
			begin
				hw_addr_ff <= buf_addr + {48'd0, off_ff}; // RULE13
				hw_data_ff <= beat.data;
				hw_bytes_ff <= beat.nbytes;
			end
		end
	end

	wire frag = info_ff.is_ipv4 && info_ff.fragmented;
	wire whole_v4 = info_ff.is_ipv4 && !info_ff.fragmented;
	wire udp_frag = frag && !info_ff.has_tcp &&
		ip_payload_checksum_enable_ff; // RULE8
	wire udp_checksum_valid = udp_frag && info_ff.has_udp && info_ff.udp_csum_ok; // RULE8
	wire ip_id_valid = frag; // RULE9
	wire udp_checksum_calculated = udp_frag || (whole_v4 && info_ff.has_udp &&
		transport_offload_setting_ff); // RULE7
	wire tcp_checksum_calculated = whole_v4 && info_ff.has_tcp &&
		transport_offload_setting_ff; // RULE7
	wire [15:0] csum = udp_frag ? info_ff.payload_csum :
		info_ff.pkt_csum; // RULE7
	wire [15:0] ipid = frag ? info_ff.ip_id : 16'd0; // RULE7
	wire [19:0] status = (info_ff.status & ~STATUS_OWN_MASK) |
		{9'd0, udp_checksum_valid, ip_id_valid, 3'd0, tcp_checksum_calculated, udp_checksum_calculated, 2'd0, !cont_ff, 1'b1};
	wire [11:0] err12 = {info_ff.err.data, info_ff.err.ipv4,
		info_ff.err.l4, info_ff.err.carrier, 1'b0, info_ff.err.seq,
		info_ff.err.symbol, info_ff.err.crc, 4'd0}; // RULE1 RULE2
	wire [63:0] q0 = hash_vs_checksum_select_ff ?
		{info_ff.rss_hash, info_ff.multi_queue_info} :
		{csum, ipid, info_ff.multi_queue_info}; // RULE6 RULE21 RULE22
	wire [63:0] q1 = {info_ff.vlan, len_ff[0], err12, status}; // RULE3 RULE4
	wire [63:0] q2 = {len_ff[3], len_ff[2], len_ff[1], split_ff, 5'd0,
		info_ff.hdr_len}; // RULE18
	wire [63:0] wb_sel = (wb_cnt_ff == 2'd0) ? q0 :
		(wb_cnt_ff == 2'd1) ? q1 :
		(wb_cnt_ff == 2'd2) ? q2 : 64'd0; // RULE23

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			wb_valid_ff <= 1'b0;
			wb_index_ff <= 2'd0;
			wb_qword_ff <= '0;
		end
		else
		begin
			wb_valid_ff <= st_ff == ST_WB;
			wb_index_ff <= wb_cnt_ff;
			wb_qword_ff <= wb_sel;
		end
	end

	assign reg_rdata = rdata_ff;
	assign desc_ready = desc_ready_ff;
	assign info_ready = info_ready_ff;
	assign beat_ready = beat_ready_ff;
	assign hw_valid = hw_valid_ff;
	assign hw_addr = hw_addr_ff;
	assign hw_data = hw_data_ff;
	assign hw_bytes = hw_bytes_ff;
	assign wb_valid = wb_valid_ff;
	assign wb_index = wb_index_ff;
	assign wb_qword = wb_qword_ff;
	assign checksum_start_offset = cstart_ff;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_split_only;
		acc && cur_ff != 2'd0 |-> split_mode;
	endproperty
	a_split_only: assert property (p_split_only) // RULE11
		else $error("Buffer above 0 used outside split mode.");

	property p_no_zero_buf;
		acc |-> cur_sz != 16'd0;
	endproperty
	a_no_zero_buf: assert property (p_no_zero_buf) // RULE16
		else $error("Write into a zero-sized buffer.");

	property p_cont_skip;
		st_ff == ST_WAIT && cont_ff && cont_start |=> cur_ff == 2'd1;
	endproperty
	a_cont_skip: assert property (p_cont_skip) // RULE17
		else $error("Continuation descriptor did not skip buffer 0.");

	property p_hw_addr;
		acc |=> hw_valid_ff && $past(off_ff) < $past(cur_sz) &&
			hw_addr_ff == $past(buf_addr) + {48'd0, $past(off_ff)};
	endproperty
	a_hw_addr: assert property (p_hw_addr) // RULE13
		else $error("Host write address not buffer base plus offset.");

	property p_len_count;
		acc && cur_ff == 2'd1 |=> len_ff[1] ==
			$past(len_ff[1]) + 16'($past(beat.nbytes));
	endproperty
	a_len_count: assert property (p_len_count) // RULE20
		else $error("Buffer 1 length did not count the stored bytes.");

	property p_len0_slot;
		wb_valid_ff && wb_index_ff == 2'd1 |->
			wb_qword_ff[47:32] == len_ff[0] && wb_qword_ff[27] == 1'b0 &&
			wb_qword_ff[23:20] == 4'd0;
	endproperty
	a_len0_slot: assert property (p_len0_slot) // RULE18
		else $error("Quadword one length or reserved error bits wrong.");

	property p_hash_slot;
		wb_valid_ff && wb_index_ff == 2'd0 && hash_vs_checksum_select_ff |->
			wb_qword_ff[63:32] == info_ff.rss_hash;
	endproperty
	a_hash_slot: assert property (p_hash_slot) // RULE22
		else $error("Hash not placed in quadword zero.");

	property p_wb_seq;
		wb_valid_ff && wb_index_ff == 2'd0 |=> wb_valid_ff &&
			wb_index_ff == 2'd1 ##1 wb_index_ff == 2'd2 ##1
			wb_index_ff == 2'd3 && wb_qword_ff == 64'd0;
	endproperty
	a_wb_seq: assert property (p_wb_seq) // RULE23
		else $error("Write-back quadword sequence broken.");

	property p_tcp_frag;
		st_ff == ST_WB && frag && info_ff.has_tcp |-> ip_id_valid && !udp_checksum_valid &&
			!udp_checksum_calculated && !tcp_checksum_calculated && csum == info_ff.pkt_csum;
	endproperty
	a_tcp_frag: assert property (p_tcp_frag) // RULE9
		else $error("Fragmented TCP flags wrong.");
endmodule // rdsw_rx_split_wb
`default_nettype wire

// file: rdsw_pkg.sv
// Function
// [RULE1] Extended error field is 12 bits with error causes at bits 11:8 and 6:4.
// [RULE2] Extended error bits 7 and 3:0 are written as zero.
// [RULE3] Packet length (buffer 0 length) sits at bit 32 of quadword one.
// [RULE4] VLAN tag sits at bit 48 of quadword one, as the parser delivers it.
// [RULE5] Software clears hash select, sets payload checksum enable, zeroes checksum start.
// [RULE6] Hash select clear writes checksum and IP identification instead of the hash.
// [RULE7] Non-IPv4 or unfragmented IPv4 reports whole-packet sum, reserved ID, valid flags clear.
// [RULE8] Fragmented IPv4 without TCP reports payload sum, ID, UDP calculated, UDP valid if good.
// [RULE9] Fragmented IPv4 with TCP reports whole sum and ID, only ID valid set.
// [RULE10] Software expects all ones when summing reassembled UDP fragments.
// [RULE11] Split format only with extended status enable and descriptor type 01.
// [RULE12] Software programs the four buffer sizes before enabling split.
// [RULE13] Four 64-bit buffer addresses per descriptor; data goes only there.
// [RULE14] Software word-aligns buffers and keeps bit 0 of address 1 zero.
// [RULE15] Header never spans buffers; too small a first buffer disables splitting.
// [RULE16] Zero-sized buffers are never written.
// [RULE17] Continuation descriptors leave their first buffer unused.
// [RULE18] Write-back reports bytes per buffer: length 0 at 8.32, lengths 1-3 at 16.16.
// [RULE19] Buffers that got no data report length zero.
// [RULE20] Lengths count every byte stored, stored CRC bytes included.
// [RULE21] Hash select picks hash or checksum pair; other fields as extended format.
// [RULE22] Hash select set places the 32-bit hash at bit 32 of quadword zero.
// [RULE23] Write-back is four quadwords; the fourth is reserved zero.
package rdsw_pkg;
	localparam logic [7:0] REG_RX_CONTROL = 8'h00;
	localparam logic [7:0] REG_RX_FILTER_CONTROL = 8'h04;
	localparam logic [7:0] REG_RX_CHECKSUM_CONTROL = 8'h08;
	localparam logic [7:0] REG_SPLIT_RX_CONTROL = 8'h0c;
	localparam logic [7:0] REG_SPLIT_STATUS = 8'h10;
	localparam int TYPE_LSB = 0;
	localparam int EXT_EN_BIT = 0;
	localparam int IPP_EN_BIT = 0;
	localparam int SELECT_BIT = 1;
	localparam int TRANSPORT_OFFLOAD_SETTING_BIT = 2;
	localparam int CSTART_LSB = 8;
	localparam int BSIZE_STRIDE = 8;
	localparam int BSIZE_W = 7;
	localparam int SIZE_UNIT_SHIFT = 7;
	localparam logic [1:0] DTYPE_SPLIT = 2'b01;
	localparam logic [1:0] DTYPE_RST = 2'h0;
	localparam logic [7:0] CSTART_RST = 8'h00;
	localparam logic [31:0] BSIZE_RST = 32'h0000_0000;
	localparam logic [19:0] STATUS_OWN_MASK = 20'h0_0633;
	localparam int DESC_WORDS = 4;
	localparam int WB_WORDS = 4;
	localparam logic [1:0] LAST_WORD = 2'd3;
	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_WAIT = 2'b01,
		ST_RECV = 2'b11,
		ST_WB = 2'b10
	} rdsw_state_t;
	typedef struct packed {
		logic data;
		logic ipv4;
		logic l4;
		logic carrier;
		logic seq;
		logic symbol;
		logic crc;
	} rdsw_err_t;
	typedef struct packed {
		logic [15:0] vlan;
		logic [19:0] status;
		rdsw_err_t err;
		logic is_ipv4;
		logic fragmented;
		logic has_tcp;
		logic has_udp;
		logic udp_csum_ok;
		logic [15:0] ip_id;
		logic [15:0] pkt_csum;
		logic [15:0] payload_csum;
		logic [31:0] rss_hash;
		logic [31:0] multi_queue_info;
		logic [9:0] hdr_len;
	} rdsw_info_t;
	typedef struct packed {
		logic [63:0] data;
		logic [3:0] nbytes;
		logic last;
	} rdsw_beat_t;
endpackage

// file: rdsw_addr_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rdsw_addr_mem #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] rd_data_ff;

	always_ff @(posedge clock)
	begin
		if (wr_en)
			mem_ff[wr_addr] <= wr_data;
		rd_data_ff <= mem_ff[rd_addr];
	end

	assign rd_data = rd_data_ff;
endmodule // rdsw_addr_mem
`default_nettype wire

// file: rdsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rdsw_host_model
	import rdsw_pkg::*;
(
	input wire logic clock,
	input wire logic hw_valid,
	input wire logic [63:0] hw_addr,
	input wire logic [63:0] hw_data,
	input wire logic [3:0] hw_bytes,
	input wire logic wb_valid,
	input wire logic [1:0] wb_index,
	input wire logic [63:0] wb_qword
);
	logic [63:0] wb_q [WB_WORDS];
	logic [63:0] wr_addr_q [$];
	logic [63:0] wr_data_q [$];
	logic [3:0] wr_bytes_q [$];
	int wb_cnt = 0;

	// Host memory keeps every data write address and the write-back words.
	always @(posedge clock)
	begin
		if (hw_valid === 1'b1)
		begin
			wr_addr_q.push_back(hw_addr);
			wr_data_q.push_back(hw_data);
			wr_bytes_q.push_back(hw_bytes);
		end
		if (wb_valid === 1'b1)
		begin
			wb_q[wb_index] = wb_qword;
			wb_cnt++;
		end
	end
endmodule // rdsw_host_model
`default_nettype wire

// file: rdsw_rx_split_wb_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rdsw_rx_split_wb_tb
	import rdsw_pkg::*;
;
	logic clock, sys_rst, reg_wr, reg_rd, desc_valid, info_valid, beat_valid;
	logic [7:0] reg_addr, checksum_start_offset;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [63:0] desc_qword, hw_addr, hw_data, wb_qword, e;
	rdsw_info_t info, inf;
	rdsw_beat_t beat;
	logic desc_ready, info_ready, beat_ready, hw_valid, wb_valid;
	logic [3:0] hw_bytes;
	logic [1:0] wb_index;
	logic [63:0] base [4];
	logic [63:0] q [4];
	logic [4:0] c;
	logic frag;
	logic [16:0] s17;
	logic [15:0] s16;
	int n_fail = 0, num_checks = 0, cycles = 0, wbs = 0, w0, i;
	int pos [7] = '{4, 5, 6, 8, 9, 10, 11};
	logic [4:0] kinds [6] = '{5'h00, 5'h1c, 5'h18, 5'h1b, 5'h1a, 5'h13};

	rdsw_rx_split_wb u_rdsw_rx_split_wb (
		.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .desc_valid, .desc_qword, .desc_ready, .info_valid,
		.info, .info_ready, .beat_valid, .beat, .beat_ready, .hw_valid,
		.hw_addr, .hw_data, .hw_bytes, .wb_valid, .wb_index, .wb_qword,
		.checksum_start_offset
	);
	rdsw_host_model u_rdsw_host_model (
		.clock, .hw_valid, .hw_addr, .hw_data, .hw_bytes, .wb_valid,
		.wb_index, .wb_qword
	);

	task chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			chk(0, 1);
			conclude;
		end
	end

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask

	function automatic logic rdy(input int s);
		return s == 0 ? desc_ready : s == 1 ? info_ready : beat_ready;
	endfunction

	// Holds the request until the edge that sees ready high.
	task automatic hs(input int s);
		int n;
		@(negedge clock);
		for (n = 0; n < 99 && rdy(s) !== 1'b1; n++)
			@(negedge clock);
		if (n == 99)
			chk(0, 1);
		@(posedge clock);
	endtask

	task automatic load(input logic [63:0] b);
		@(posedge clock);
		for (int k = 0; k < 4; k++)
		begin
			base[k] = b + 64'(k) * 64'h0000_0000_0001_0000;
			desc_valid <= 1'b1;
			desc_qword <= base[k];
			hs(0);
		end
		desc_valid <= 1'b0;
	endtask

	task automatic beats(input int n, input logic [3:0] t, input bit z);
		for (int k = 0; k < n; k++)
		begin
			beat_valid <= 1'b1;
			beat <= '{64'h00a5_0000_0000_0000 + 64'(k),
				k == n - 1 ? t : 4'h8, z && k == n - 1};
			hs(2);
		end
		beat_valid <= 1'b0;
	endtask

	task pkt(input rdsw_info_t f, input int n, input logic [3:0] t, input bit z);
		@(posedge clock);
		info_valid <= 1'b1;
		info <= f;
		hs(1);
		info_valid <= 1'b0;
		beats(n, t, z);
	endtask

	task automatic getq;
		int n;
		wbs += 4;
		for (n = 0; n < 99 && u_rdsw_host_model.wb_cnt < wbs; n++)
			@(negedge clock);
		if (n == 99)
			chk(0, 1);
		q = u_rdsw_host_model.wb_q;
	endtask

	initial
	begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, desc_valid, info_valid, beat_valid} = '0;
		reg_addr = '0;
		reg_wdata = '0;
		desc_qword = '0;
		info = '0;
		beat = '0;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		wr(8'h20, 32'hffff_ffff);
		for (i = 0; i < 5; i++)
		begin
			rdr(i == 4 ? 8'h20 : 8'(i * 4), rd);
			chk(rd, 0);
		end
		wr(8'h0c, 32'h0000_0101);
		wr(8'h08, 32'h0000_5a03);
		rdr(8'h0c, rd);
		chk(rd, 32'h0000_0101);
		chk(checksum_start_offset, 8'h5a);
		for (i = 0; i < 7; i++)
		begin
			inf = '0;
			inf.err = 7'(1 << i);
			inf.vlan = 16'h0e00 + 16'(i);
			inf.rss_hash = 32'h1234_5600 + 32'(i);
			inf.multi_queue_info = 32'h0000_0007;
			w0 = u_rdsw_host_model.wr_addr_q.size();
			load(64'h0000_0001_0000_0000);
			pkt(inf, 1, 4'(i + 1), 1'b1);
			getq;
			chk(q[0], {inf.rss_hash, inf.multi_queue_info});
			e = {inf.vlan, 16'(i + 1), 12'(1 << pos[i])};
			chk(q[1][63:20], e);
			chk(q[1][1:0], 2'b11);
			chk(q[2][63:16], 0);
			chk(q[3], 0);
			chk(u_rdsw_host_model.wr_addr_q[w0], base[0]);
			chk(u_rdsw_host_model.wr_data_q[w0],
				64'h00a5_0000_0000_0000);
			chk(u_rdsw_host_model.wr_bytes_q[w0], 4'(i + 1));
		end
		wr(8'h08, 32'h0000_0005);
		s16 = '0;
		for (i = 0; i < 6; i++)
		begin
			c = kinds[i];
			frag = c[4] & c[3];
			inf = '0;
			{inf.is_ipv4, inf.fragmented, inf.has_tcp, inf.has_udp,
				inf.udp_csum_ok} = c;
			inf.ip_id = 16'h4d00 + 16'(i);
			inf.pkt_csum = 16'hc100 + 16'(i);
			inf.payload_csum = (i == 4) ? ~s16 : 16'h9900 + 16'(i);
			load(64'h0000_0001_0000_0000);
			pkt(inf, 1, 4'h8, 1'b1);
			getq;
			e = (frag & !c[2]) ? inf.payload_csum : inf.pkt_csum;
			chk(q[0][63:48], e);
			if (frag)
				chk(q[0][47:32], inf.ip_id);
			e = {frag & c[1] & c[0] & !c[2], frag};
			chk(q[1][10:9], e);
			chk(q[1][5:4], {c[4] & !c[3] & c[2],
				(frag & !c[2]) | (c[4] & !c[3] & c[1])});
			if (frag & !c[2])
			begin
				s17 = {1'b0, s16} + {1'b0, q[0][63:48]};
				s16 = s17[15:0] + 16'(s17[16]);
			end
		end
		chk(s16, 16'hffff);
		chk(checksum_start_offset, 0);
		wr(8'h08, 32'h0000_0003);
		wr(8'h00, 32'h0000_0001);
		inf = '0;
		inf.hdr_len = 10'h010;
		inf.rss_hash = 32'h5a5a_0001;
		load(64'h0000_0002_0000_0000);
		pkt(inf, 3, 4'h8, 1'b1);
		getq;
		chk(q[1][47:32], 24);
		chk({q[2][63:16], q[2][15]}, 0);
		wr(8'h04, 32'h0000_0001);
		w0 = u_rdsw_host_model.wr_addr_q.size();
		load(64'h0000_0002_0000_0000);
		pkt(inf, 18, 4'h8, 1'b0);
		getq;
		chk(q[0], {inf.rss_hash, 32'h0000_0000});
		chk(q[1][47:32], 16);
		chk(q[2], 64'h0000_0000_0080_8010);
		chk(q[1][1:0], 2'b01);
		chk(u_rdsw_host_model.wr_addr_q[w0 + 2], base[1]);
		chk(u_rdsw_host_model.wr_addr_q[w0 + 17], base[1] + 120);
		chk(u_rdsw_host_model.wr_data_q[w0 + 17],
			64'h00a5_0000_0000_0011);
		load(64'h0000_0003_0000_0000);
		beats(2, 4'h4, 1'b1);
		getq;
		chk(q[1][47:32], 0);
		chk(q[2][31:16], 12);
		chk(q[1][1:0], 2'b11);
		chk(u_rdsw_host_model.wr_addr_q[w0 + 18], base[1]);
		conclude;
	end
endmodule // rdsw_rx_split_wb_tb
`default_nettype wire
